/* vrt_map.svh */
// register offsets, field positions, reset values and timing counts for the reference control block
`ifndef VRT_MAP_SVH
`define VRT_MAP_SVH

`define VRT_ADDR_W            4
`define VRT_CTRL_OFS          4'h0
`define VRT_IRQ_STAT_OFS      4'h1
`define VRT_IRQ_MASK_OFS      4'h2
`define VRT_CTRL_RST          8'h00
`define VRT_IRQ_RST           8'h00
`define VRT_BIT_REF_EN        7
`define VRT_BIT_REF_RDY       6
`define VRT_BIT_TS_EN         5
`define VRT_BIT_TS_RNG        4
`define VRT_IRQ_BIT_RDY_RISE  0
`define VRT_IRQ_BIT_RDY_FALL  1
`define VRT_IRQ_BITS          2
`define VRT_GAIN_1X           2'h1
`define VRT_GAIN_2X           2'h2
`define VRT_OSC_SEL_INTOSC    2'h0
`define VRT_BOR_ALWAYS        2'h3
`define VRT_BOR_NOSLEEP       2'h2
`define VRT_BOR_SOFT          2'h1
`define VRT_SETTLE_NS         25000
`define VRT_CLK_PERIOD_NS     4
`define VRT_SETTLE_CYC        ((`VRT_SETTLE_NS + `VRT_CLK_PERIOD_NS - 1) / `VRT_CLK_PERIOD_NS)

`endif

/* vrt_pkg.sv */
// types shared by the reference control block
package vrt_pkg;
    typedef enum logic [1:0] {
        VRT_REF_OFF,
        VRT_REF_SETTLING,
        VRT_REF_READY
    } vrt_ref_state_t;

    typedef enum logic [1:0] {
        VRT_GAIN_OFF,
        VRT_GAIN_X1,
        VRT_GAIN_X2
    } vrt_gain_t;
endpackage

/* vrt_sync.sv */
// three-stage synchroniser with agreement on the last two stages
`timescale 1ns/10ps
module vrt_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             resetn_i,
    // asynchronous levels in, settled levels out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] mid_r;
    logic [WIDTH-1:0] last_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] level_nxt;

    // a bit changes only once the second and third stage agree
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            level_nxt[i] = (mid_r[i] == last_r[i]) ? last_r[i] : level_r[i];
        end
    end

    // the first stage feeds only the second
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            meta_r  <= '0;
            mid_r   <= '0;
            last_r  <= '0;
            level_r <= '0;
        end
        else
        begin
            meta_r  <= async_i;
            mid_r   <= meta_r;
            last_r  <= mid_r;
            level_r <= level_nxt;
        end
    end

    assign level_o = level_r;
endmodule

/* vrt_ref_ctrl.sv */
// control register, settling tracker and interrupt for the fixed voltage reference and temperature indicator
// Functional notes
// - Bit 7 of the control register turns the fixed voltage reference on when set and off when clear.
// - Once the enabled reference has settled, the read-only ready flag in bit 6 is set.
// - The ready flag reads zero while the reference is unsettled or powered off.
// - Bit 5 turns the temperature indicator on when set and off when clear.
// - Bit 4 picks the temperature indicator range, one for high and zero for low.
// - Bits 1 to 0 pick the reference to the converter: 01 is 1x, 10 is 2x, 00 and 11 are off.
// - Bits 3 and 2 are not implemented and always read zero.
// - The reference stays on while the internal fast oscillator runs outside sleep (select 00, frequency 000x).
// - The reference stays on for brown-out reset when its mode is 11, or 10 or 01 with fast start set.
// - The temperature indicator output is routed to a reserved converter input channel.
`timescale 1ns/10ps
`include "vrt_map.svh"
module vrt_ref_ctrl #(
    parameter int SETTLE_CYC = `VRT_SETTLE_CYC
) (
    // clock and reset
    input  wire logic                    core_clk_i,
    input  wire logic                    resetn_i,
    // register port
    input  wire logic [`VRT_ADDR_W-1:0]  reg_addr_i,
    input  wire logic [7:0]              reg_wdata_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    output logic      [7:0]              reg_rdata_o,
    // oscillator and brown-out configuration
    input  wire logic [1:0]              osc_select_i,
    input  wire logic [3:0]              int_osc_freq_select_i,
    input  wire logic                    sleep_i,
    input  wire logic [1:0]              brownout_enable_mode_i,
    input  wire logic                    brownout_fast_start_i,
    // analog side
    input  wire logic                    ref_settled_i,
    output logic                         fixed_voltage_reference_on_o,
    output logic                         adc_ref_x1_o,
    output logic                         adc_ref_x2_o,
    output logic                         temp_sense_enable_o,
    output logic                         temp_range_select_o,
    output logic                         temp_to_adc_channel_o,
    output logic                         ref_ready_o,
    // interrupt
    output logic                         irq_o
);
    localparam int CNT_W = $clog2(SETTLE_CYC + 1);

    logic [7:0]                 ctrl_r;
    logic [7:0]                 ctrl_nxt;
    logic [`VRT_IRQ_BITS-1:0]   stat_r;
    logic [`VRT_IRQ_BITS-1:0]   stat_nxt;
    logic [`VRT_IRQ_BITS-1:0]   mask_r;
    logic [`VRT_IRQ_BITS-1:0]   mask_nxt;
    logic [7:0]                 rdata_r;
    logic [7:0]                 rdata_nxt;
    vrt_pkg::vrt_ref_state_t    state_r;
    vrt_pkg::vrt_ref_state_t    state_nxt;
    logic [CNT_W-1:0]           cnt_r;
    logic [CNT_W-1:0]           cnt_nxt;
    logic                       ready_r;
    logic                       ready_nxt;
    logic                       ref_on_r;
    logic                       ref_on_nxt;
    logic                       x1_r;
    logic                       x1_nxt;
    logic                       x2_r;
    logic                       x2_nxt;
    logic                       ts_en_r;
    logic                       ts_en_nxt;
    logic                       ts_rng_r;
    logic                       ts_rng_nxt;
    logic                       irq_r;
    logic                       irq_nxt;
    logic [8:0]                 cfg_sync;
    logic                       settled_sync;
    logic [1:0]                 osc_sel_sync;
    logic [2:0]                 freq_hi_sync;
    logic                       awake_sync;
    logic                       bor_lo_sync;
    logic                       fast_start_sync;
    logic                       osc_needs;
    logic                       bor_needs;
    logic                       ref_demand;
    logic                       wr_ctrl;
    logic                       wr_stat;
    logic                       wr_mask;
    vrt_pkg::vrt_gain_t         gain;

    // oscillator, brown-out and settle levels come from other domains and pins
    // sleep travels inverted: a freshly reset stage reads asleep, so no false demand follows reset
    vrt_sync #(
        .WIDTH (10)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .async_i    ({ref_settled_i, osc_select_i, int_osc_freq_select_i, ~sleep_i,
                      brownout_enable_mode_i[0], brownout_fast_start_i}),
        .level_o    ({settled_sync, cfg_sync})
    );

    // bor mode bit 1 travels separately to keep the bundle readable
    logic bor_hi_sync;
    vrt_sync #(
        .WIDTH (1)
    ) u_sync_bor (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .async_i    (brownout_enable_mode_i[1]),
        .level_o    (bor_hi_sync)
    );

    // settled configuration fields; the lowest frequency bit takes no part in the match
    assign osc_sel_sync    = cfg_sync[8:7];
    assign freq_hi_sync    = cfg_sync[6:4];
    assign awake_sync      = cfg_sync[2];
    assign bor_lo_sync     = cfg_sync[1];
    assign fast_start_sync = cfg_sync[0];

    // who forces the reference on; brown-out modes 10 and 01 force it only with fast start
    always_comb
    begin
        osc_needs = (osc_sel_sync == `VRT_OSC_SEL_INTOSC) && (freq_hi_sync == 3'h0)
                    && awake_sync;
        case ({bor_hi_sync, bor_lo_sync})
            `VRT_BOR_ALWAYS:  bor_needs = 1'b1;
            `VRT_BOR_NOSLEEP: bor_needs = fast_start_sync;
            `VRT_BOR_SOFT:    bor_needs = fast_start_sync;
            default:          bor_needs = 1'b0;
        endcase
        // the written enable counts in its own cycle, so power follows a write by one clock
        ref_demand = ctrl_nxt[`VRT_BIT_REF_EN] || osc_needs || bor_needs;
    end

    // register port decode
    always_comb
    begin
        wr_ctrl = reg_wr_i && (reg_addr_i == `VRT_CTRL_OFS);
        wr_stat = reg_wr_i && (reg_addr_i == `VRT_IRQ_STAT_OFS);
        wr_mask = reg_wr_i && (reg_addr_i == `VRT_IRQ_MASK_OFS);
    end

    // control register: ready and unused bits are never stored
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl)
        begin
            ctrl_nxt = reg_wdata_i & 8'hB3;
        end
        mask_nxt = wr_mask ? reg_wdata_i[`VRT_IRQ_BITS-1:0] : mask_r;
    end

    // settling tracker: analog ready plus a minimum settle count
    // a settled glitch keeps the count, so ready returns as soon as the level does
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            vrt_pkg::VRT_REF_OFF:
            begin
                cnt_nxt = '0;
                if (ref_demand)
                begin
                    state_nxt = vrt_pkg::VRT_REF_SETTLING;
                end
            end
            vrt_pkg::VRT_REF_SETTLING:
            begin
                if (!ref_demand)
                begin
                    state_nxt = vrt_pkg::VRT_REF_OFF;
                end
                else if ((cnt_r >= CNT_W'(SETTLE_CYC - 1)) && settled_sync)
                begin
                    state_nxt = vrt_pkg::VRT_REF_READY;
                end
                else if (cnt_r < CNT_W'(SETTLE_CYC - 1))
                begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            vrt_pkg::VRT_REF_READY:
            begin
                if (!ref_demand)
                begin
                    state_nxt = vrt_pkg::VRT_REF_OFF;
                end
                else if (!settled_sync)
                begin
                    state_nxt = vrt_pkg::VRT_REF_SETTLING;
                end
            end
            default:
            begin
                state_nxt = vrt_pkg::VRT_REF_OFF;
            end
        endcase
        ready_nxt = (state_nxt == vrt_pkg::VRT_REF_READY);
    end

    // gain and indicator decode; 00 and 11 both leave the converter path off
    always_comb
    begin
        case (ctrl_nxt[1:0])
            `VRT_GAIN_1X: gain = vrt_pkg::VRT_GAIN_X1;
            `VRT_GAIN_2X: gain = vrt_pkg::VRT_GAIN_X2;
            default:      gain = vrt_pkg::VRT_GAIN_OFF;
        endcase
        ref_on_nxt = (state_nxt != vrt_pkg::VRT_REF_OFF);
        x1_nxt     = (gain == vrt_pkg::VRT_GAIN_X1);
        x2_nxt     = (gain == vrt_pkg::VRT_GAIN_X2);
        ts_en_nxt  = ctrl_nxt[`VRT_BIT_TS_EN];
        ts_rng_nxt = ctrl_nxt[`VRT_BIT_TS_RNG];
    end

    // sticky events; a new event beats a same-cycle clear
    // write one to clear; bits written zero are left alone
    always_comb
    begin
        stat_nxt = stat_r;
        if (wr_stat)
        begin
            stat_nxt = stat_r & ~reg_wdata_i[`VRT_IRQ_BITS-1:0];
        end
        if (ready_nxt && !ready_r)
        begin
            stat_nxt[`VRT_IRQ_BIT_RDY_RISE] = 1'b1;
        end
        if (!ready_nxt && ready_r)
        begin
            stat_nxt[`VRT_IRQ_BIT_RDY_FALL] = 1'b1;
        end
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    // read mux; the ready bit is live state, bits 3-2 are zero
    // unmapped indices read zero, and writes to them are dropped
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `VRT_CTRL_OFS:     rdata_nxt = {ctrl_r[7], ready_r, ctrl_r[5:4], 2'h0, ctrl_r[1:0]};
                `VRT_IRQ_STAT_OFS: rdata_nxt = {6'h00, stat_r};
                `VRT_IRQ_MASK_OFS: rdata_nxt = {6'h00, mask_r};
                default:           rdata_nxt = 8'h00;
            endcase
        end
    end

    // all state registers
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_r   <= `VRT_CTRL_RST;
            stat_r   <= '0;
            mask_r   <= '0;
            rdata_r  <= 8'h00;
            state_r  <= vrt_pkg::VRT_REF_OFF;
            cnt_r    <= '0;
            ready_r  <= 1'b0;
            ref_on_r <= 1'b0;
            x1_r     <= 1'b0;
            x2_r     <= 1'b0;
            ts_en_r  <= 1'b0;
            ts_rng_r <= 1'b0;
            irq_r    <= 1'b0;
        end
        else
        begin
            ctrl_r   <= ctrl_nxt;
            stat_r   <= stat_nxt;
            mask_r   <= mask_nxt;
            rdata_r  <= rdata_nxt;
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            ready_r  <= ready_nxt;
            ref_on_r <= ref_on_nxt;
            x1_r     <= x1_nxt;
            x2_r     <= x2_nxt;
            ts_en_r  <= ts_en_nxt;
            ts_rng_r <= ts_rng_nxt;
            irq_r    <= irq_nxt;
        end
    end

    // outputs straight from flops; the indicator feeds the reserved channel whenever on
    // irq is a level: it stays high until software clears the status bit or its mask bit
    assign reg_rdata_o                  = rdata_r;
    assign fixed_voltage_reference_on_o = ref_on_r;
    assign adc_ref_x1_o                 = x1_r;
    assign adc_ref_x2_o                 = x2_r;
    assign temp_sense_enable_o          = ts_en_r;
    assign temp_range_select_o          = ts_rng_r;
    assign temp_to_adc_channel_o        = ts_en_r;
    assign ref_ready_o                  = ready_r;
    assign irq_o                        = irq_r;
endmodule

/* vrt_analog_model.sv */
// behavioural analogue reference: reports settled some cycles after power-up
`timescale 1ns/10ps
module vrt_analog_model (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic resetn_i,
    // power request and pace
    input  wire logic ref_on_i,
    input  wire logic slow_i,
    // settled indication
    output logic      ref_settled_o
);
    int unsigned cnt;

    // counts powered cycles; power loss drops settled at once, as a real bandgap would
    always_ff @(posedge core_clk_i or negedge resetn_i)
        if (!resetn_i)
            cnt <= 0;
        else
            cnt <= ref_on_i ? cnt + 1 : 0;

    // slow pace keeps the output unsettled well past the digital settle count
    assign ref_settled_o = ref_on_i && cnt >= (slow_i ? 60 : 2);
endmodule

/* vrt_ref_ctrl_chk.sv */
// port assertions for the reference control block
`timescale 1ns/10ps
`include "vrt_map.svh"
module vrt_ref_ctrl_chk #(
    parameter int SETTLE_CYC = 4
) (
    // clock, reset, register port
    input wire logic                   core_clk_i,
    input wire logic                   resetn_i,
    input wire logic [`VRT_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0]             reg_wdata_i,
    input wire logic                   reg_wr_i,
    input wire logic                   reg_rd_i,
    input wire logic [7:0]             reg_rdata_o,
    // demand sources
    input wire logic [1:0]             osc_select_i,
    input wire logic [3:0]             int_osc_freq_select_i,
    input wire logic                   sleep_i,
    input wire logic [1:0]             brownout_enable_mode_i,
    input wire logic                   brownout_fast_start_i,
    // analogue side and interrupt
    input wire logic                   ref_settled_i,
    input wire logic                   fixed_voltage_reference_on_o,
    input wire logic                   adc_ref_x1_o,
    input wire logic                   adc_ref_x2_o,
    input wire logic                   temp_sense_enable_o,
    input wire logic                   temp_range_select_o,
    input wire logic                   temp_to_adc_channel_o,
    input wire logic                   ref_ready_o,
    input wire logic                   irq_o
);
    localparam int RDY_MAX = SETTLE_CYC + 8;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    // steps of a control write, a control read and of power-up
    sequence s_ctrl_wr;
        reg_wr_i && reg_addr_i == `VRT_CTRL_OFS;
    endsequence
    sequence s_turn_on;
        $rose(fixed_voltage_reference_on_o);
    endsequence
    sequence s_ctrl_rd;
        reg_rd_i && reg_addr_i == `VRT_CTRL_OFS;
    endsequence

    a_ref_enable: assert property (s_ctrl_wr ##0 reg_wdata_i[7] |=> fixed_voltage_reference_on_o)
        else $error("reference off after enable write");
    a_gain_select: assert property (s_ctrl_wr ##0 reg_wdata_i[7] |=>
        adc_ref_x1_o == ($past(reg_wdata_i[1:0]) == 2'h1) && adc_ref_x2_o == ($past(reg_wdata_i[1:0]) == 2'h2))
        else $error("gain outputs disagree with written field");
    a_temp_bits: assert property (s_ctrl_wr |=> {temp_sense_enable_o, temp_range_select_o} == $past(reg_wdata_i[5:4]))
        else $error("temperature outputs disagree with write");
    a_temp_route: assert property (temp_to_adc_channel_o == temp_sense_enable_o)
        else $error("temperature channel routing wrong");
    a_ready_off: assert property (!fixed_voltage_reference_on_o [*2] |-> !ref_ready_o)
        else $error("ready while reference off");
    a_ready_unsettled: assert property (!ref_settled_i [*8] |-> !ref_ready_o)
        else $error("ready while unsettled");
    a_settle_wait: assert property (s_turn_on |-> !ref_ready_o [*8])
        else $error("ready before settle count");
    a_ready_reach: assert property ((fixed_voltage_reference_on_o && ref_settled_i) [*8] |-> ##[0:RDY_MAX] ref_ready_o)
        else $error("ready never set");
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside read cycle");
    a_unimpl_zero: assert property (s_ctrl_rd |=> reg_rdata_o[3:2] == 2'h0)
        else $error("unimplemented bits read nonzero");
    a_ready_ro: assert property (s_ctrl_rd |=> reg_rdata_o[6] == $past(ref_ready_o))
        else $error("ready bit differs from flag");
    a_bor_demand: assert property ((brownout_enable_mode_i == `VRT_BOR_ALWAYS ||
        (brownout_enable_mode_i != 2'h0 && brownout_fast_start_i)) [*6] |-> fixed_voltage_reference_on_o)
        else $error("brown-out demand ignored");
    a_osc_demand: assert property ((osc_select_i == `VRT_OSC_SEL_INTOSC &&
        int_osc_freq_select_i[3:1] == 3'h0 && !sleep_i) [*6] |-> fixed_voltage_reference_on_o)
        else $error("oscillator demand ignored");
endmodule

bind vrt_ref_ctrl vrt_ref_ctrl_chk #(
    .SETTLE_CYC (SETTLE_CYC)
) i_chk (
    .core_clk_i (core_clk_i),
    .resetn_i (resetn_i),
    .reg_addr_i (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_wr_i (reg_wr_i),
    .reg_rd_i (reg_rd_i),
    .reg_rdata_o (reg_rdata_o),
    .osc_select_i (osc_select_i),
    .int_osc_freq_select_i (int_osc_freq_select_i),
    .sleep_i (sleep_i),
    .brownout_enable_mode_i (brownout_enable_mode_i),
    .brownout_fast_start_i (brownout_fast_start_i),
    .ref_settled_i (ref_settled_i),
    .fixed_voltage_reference_on_o (fixed_voltage_reference_on_o),
    .adc_ref_x1_o (adc_ref_x1_o),
    .adc_ref_x2_o (adc_ref_x2_o),
    .temp_sense_enable_o (temp_sense_enable_o),
    .temp_range_select_o (temp_range_select_o),
    .temp_to_adc_channel_o (temp_to_adc_channel_o),
    .ref_ready_o (ref_ready_o),
    .irq_o (irq_o)
);

/* tb.sv */
// testbench for the reference control block
`timescale 1ns/10ps
`include "vrt_map.svh"
module tb;
    logic                   core_clk_i;
    logic                   resetn_i;
    logic [`VRT_ADDR_W-1:0] reg_addr_i;
    logic [7:0]             reg_wdata_i;
    logic                   reg_wr_i;
    logic                   reg_rd_i;
    logic [7:0]             reg_rdata_o;
    logic [1:0]             osc_select_i;
    logic [3:0]             int_osc_freq_select_i;
    logic                   sleep_i;
    logic [1:0]             brownout_enable_mode_i;
    logic                   brownout_fast_start_i;
    logic                   ref_settled_i;
    logic                   fixed_voltage_reference_on_o;
    logic                   adc_ref_x1_o;
    logic                   adc_ref_x2_o;
    logic                   temp_sense_enable_o;
    logic                   temp_range_select_o;
    logic                   temp_to_adc_channel_o;
    logic                   ref_ready_o;
    logic                   irq_o;
    logic                   slow;
    int                     err_total;
    int                     n_checks;
    // {osc, freq, sleep, bor mode, fast start, expected power}
    logic [10:0]            dem [8] = '{11'h20D, 11'h208, 11'h20B, 11'h207, 11'h204, 11'h021, 11'h030, 11'h040};

    // a settle count longer than the settled-level sync delay, so the counter itself is seen
    vrt_ref_ctrl #(
        .SETTLE_CYC (8)
    ) i_dut (
        .core_clk_i (core_clk_i),
        .resetn_i (resetn_i),
        .reg_addr_i (reg_addr_i),
        .reg_wdata_i (reg_wdata_i),
        .reg_wr_i (reg_wr_i),
        .reg_rd_i (reg_rd_i),
        .reg_rdata_o (reg_rdata_o),
        .osc_select_i (osc_select_i),
        .int_osc_freq_select_i (int_osc_freq_select_i),
        .sleep_i (sleep_i),
        .brownout_enable_mode_i (brownout_enable_mode_i),
        .brownout_fast_start_i (brownout_fast_start_i),
        .ref_settled_i (ref_settled_i),
        .fixed_voltage_reference_on_o (fixed_voltage_reference_on_o),
        .adc_ref_x1_o (adc_ref_x1_o),
        .adc_ref_x2_o (adc_ref_x2_o),
        .temp_sense_enable_o (temp_sense_enable_o),
        .temp_range_select_o (temp_range_select_o),
        .temp_to_adc_channel_o (temp_to_adc_channel_o),
        .ref_ready_o (ref_ready_o),
        .irq_o (irq_o)
    );
    vrt_analog_model i_model (
        .core_clk_i    (core_clk_i),
        .resetn_i      (resetn_i),
        .ref_on_i      (fixed_voltage_reference_on_o),
        .slow_i        (slow),
        .ref_settled_o (ref_settled_i)
    );

    // 250 MHz clock
    initial
    begin
        core_clk_i = 1'h0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    task automatic results();
        if (err_total == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // let registered outputs land before sampling
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'h1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'h0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'h1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'h0;
        #1;
        chk("rdata", reg_rdata_o, exp);
    endtask

    // bounded wait so a missing flag cannot hang the run
    task automatic wait_ready();
        int i;
        for (i = 0; i < 300 && ref_ready_o !== 1'h1; i++)
            tick(1);
        if (i == 300)
        begin
            err_total++;
            results();
        end
    endtask

    // watchdog
    initial
    begin
        repeat (50000) @(posedge core_clk_i);
        err_total++;
        results();
    end

    // main sequence
    initial
    begin
        err_total = 0;
        n_checks = 0;
        slow = 1'h1;
        resetn_i = 1'h0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'h0;
        reg_rd_i = 1'h0;
        osc_select_i = 2'h1;
        int_osc_freq_select_i = 4'h0;
        sleep_i = 1'h0;
        brownout_enable_mode_i = 2'h0;
        brownout_fast_start_i = 1'h0;
        repeat (20) @(posedge core_clk_i);
        resetn_i <= 1'h1;
        rd(`VRT_CTRL_OFS, `VRT_CTRL_RST);
        rd(`VRT_IRQ_STAT_OFS, `VRT_IRQ_RST);
        rd(`VRT_IRQ_MASK_OFS, `VRT_IRQ_RST);
        // every gain code, with ready, reserved and temperature bits written high
        for (int g = 0; g < 4; g++)
        begin
            wr(`VRT_CTRL_OFS, 8'hFC | 8'(g));
            tick(1);
            chk("gain", {6'h00, adc_ref_x2_o, adc_ref_x1_o}, {6'h00, g == 2, g == 1});
            chk("ref_on", {7'h00, fixed_voltage_reference_on_o}, 8'h01);
            chk("temp", {5'h00, temp_to_adc_channel_o, temp_sense_enable_o, temp_range_select_o}, 8'h07);
            rd(`VRT_CTRL_OFS, 8'hB0 | 8'(g));
        end
        // indicator on with no conversion started, so the host's 200 us channel wait never comes due
        wr(`VRT_CTRL_OFS, 8'h20);
        tick(1);
        chk("temp", {5'h00, temp_to_adc_channel_o, temp_sense_enable_o, temp_range_select_o}, 8'h06);
        chk("ref_on", {7'h00, fixed_voltage_reference_on_o}, 8'h00);
        // settle, interrupt raise, mask and clear
        slow <= 1'h0;
        wr(`VRT_IRQ_STAT_OFS, 8'h03);
        wr(`VRT_CTRL_OFS, 8'h81);
        wait_ready();
        rd(`VRT_CTRL_OFS, 8'hC1);
        rd(`VRT_IRQ_STAT_OFS, 8'h01);
        chk("irq", {7'h00, irq_o}, 8'h00);
        wr(`VRT_IRQ_MASK_OFS, 8'h01);
        tick(2);
        chk("irq", {7'h00, irq_o}, 8'h01);
        wr(`VRT_IRQ_STAT_OFS, 8'h01);
        tick(2);
        chk("irq", {7'h00, irq_o}, 8'h00);
        // disable while writing a one to the ready bit
        wr(`VRT_CTRL_OFS, 8'h41);
        tick(2);
        chk("ready", {7'h00, ref_ready_o}, 8'h00);
        rd(`VRT_CTRL_OFS, 8'h01);
        rd(`VRT_IRQ_STAT_OFS, 8'h02);
        wr(4'h5, 8'hFF);
        rd(4'h5, 8'h00);
        wr(`VRT_CTRL_OFS, 8'h00);
        // oscillator and brown-out demand table
        foreach (dem[k])
        begin
            @(posedge core_clk_i);
            {osc_select_i, int_osc_freq_select_i, sleep_i, brownout_enable_mode_i, brownout_fast_start_i} <= dem[k][10:1];
            tick(8);
            chk("ref_on", {7'h00, fixed_voltage_reference_on_o}, {7'h00, dem[k][0]});
        end
        results();
    end
endmodule
